// File: rtc_cfg.svh
// Constants of the clock: register offsets, field positions, resets
// Assumes inclusion by bare name from the clock design files
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// Seven-bit slave address, D0h once the direction bit is appended
`define RTC_SLAVE_ADDR      7'h68
`define RTC_ADDR_BYTE_WR    8'hD0

// Register offsets
`define RTC_REG_SEC         3'h0
`define RTC_REG_MIN         3'h1
`define RTC_REG_HOUR        3'h2
`define RTC_REG_DOW         3'h3
`define RTC_REG_DATE        3'h4
`define RTC_REG_CMON        3'h5
`define RTC_REG_YEAR        3'h6
`define RTC_REG_CAL         3'h7
`define RTC_LAST_CLOCK_ADDR 3'h6

// Field positions
`define RTC_HALT_BIT        7
`define RTC_OSC_FAIL_IRQ_ENABLE_BIT        7
`define RTC_CENT_LSB        6
`define RTC_CENT_MSB        7
`define RTC_DOW_MSB         2

// Reset contents, byte n at bits 8n+7..8n
`define RTC_RST_TIME        64'h0000_0101_0100_0000

// Crystal rate in Hz
`define RTC_OSC_HZ          32768

`endif

// File: rtc_core.sv
// Timekeeping core: crystal divider, BCD counters, register store
// Assumes write and snapshot toggles come from another clock domain
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"

module rtc_core
   import rtc_pkg::*;
#(
   parameter int OSC_HZ = `RTC_OSC_HZ
) (
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_crystal_in,
   input  wire logic        i_wr_tgl,
   input  wire logic [2:0]  i_wr_addr,
   input  wire logic [7:0]  i_wr_data,
   input  wire logic        i_snap_req,
   output logic             o_snap_ack,
   output logic [63:0]      o_snap_data
);

   localparam int DIV_W = $clog2(OSC_HZ);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_HZ - 1);
   localparam logic [63:0]      RST_TIME = `RTC_RST_TIME;

   logic [2:0]       xtal_sync_reg;
   logic [2:0]       wr_sync_reg;
   logic [1:0]       req_sync_reg;
   logic [DIV_W-1:0] div_reg;
   rtc_byte_t        tm_reg [8];
   rtc_byte_t        tm_next [8];
   logic [63:0]      tm_flat;
   rtc_byte_t        nxt_sec, nxt_min, nxt_hr, nxt_dow;
   rtc_byte_t        nxt_date, nxt_mon, nxt_yr;
   logic             wr_stb;
   logic             halt;
   logic             tick;

   function automatic rtc_byte_t bcd_inc(input rtc_byte_t v,
                                         input rtc_byte_t lo,
                                         input rtc_byte_t hi);
      if (v == hi) begin
         return lo;
      end else if (v[3:0] == 4'h9) begin
         return {v[7:4] + 4'h1, 4'h0};
      end
      return v + 8'h01;
   endfunction

   function automatic rtc_byte_t month_last(input rtc_byte_t m,
                                            input rtc_byte_t y);
      logic leap;
      leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                  : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
      case (m)
         8'h02: return leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
         default: return 8'h31;
      endcase
   endfunction

   // Synchronisers for crystal and cross-domain toggles
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         xtal_sync_reg <= 3'h0;
         wr_sync_reg   <= 3'h0;
         req_sync_reg  <= 2'h0;
      end else begin
         xtal_sync_reg <= {xtal_sync_reg[1:0], i_crystal_in};
         wr_sync_reg   <= {wr_sync_reg[1:0], i_wr_tgl};
         req_sync_reg  <= {req_sync_reg[0], i_snap_req};
      end
   end

   assign wr_stb = wr_sync_reg[1] ^ wr_sync_reg[2];
   assign halt   = tm_reg[`RTC_REG_SEC][`RTC_HALT_BIT];

   // One-second divider
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         div_reg <= '0;
      end else if (wr_stb && i_wr_addr <= `RTC_LAST_CLOCK_ADDR) begin
         div_reg <= '0;
      end else if (xtal_sync_reg[1] && !xtal_sync_reg[2] && !halt) begin
         div_reg <= (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
      end
   end

   assign tick = xtal_sync_reg[1] && !xtal_sync_reg[2] && !halt &&
                 (div_reg == DIV_LAST);

   // Calendar cascade
   always_comb begin
      tm_next  = tm_reg;
      nxt_sec  = bcd_inc({1'b0, tm_reg[0][6:0]}, 8'h00, 8'h59);
      nxt_min  = bcd_inc({1'b0, tm_reg[1][6:0]}, 8'h00, 8'h59);
      nxt_hr   = bcd_inc(tm_reg[2] & 8'h3f, 8'h00, 8'h23);
      nxt_dow  = bcd_inc(tm_reg[3] & 8'h07, 8'h01, 8'h07);
      nxt_date = bcd_inc(tm_reg[4] & 8'h3f, 8'h01,
                         month_last(tm_reg[5] & 8'h1f, tm_reg[6]));
      nxt_mon  = bcd_inc(tm_reg[5] & 8'h1f, 8'h01, 8'h12);
      nxt_yr   = bcd_inc(tm_reg[6], 8'h00, 8'h99);
      if (tick) begin
         tm_next[0][6:0] = nxt_sec[6:0];
         if (tm_reg[0][6:0] == 7'h59) begin
            tm_next[1][6:0] = nxt_min[6:0];
            if (tm_reg[1][6:0] == 7'h59) begin
               tm_next[2] = nxt_hr;
               if (tm_reg[2][5:0] == 6'h23) begin
                  tm_next[3] = nxt_dow;
                  tm_next[4] = nxt_date;
                  if (nxt_date == 8'h01) begin
                     tm_next[5][4:0] = nxt_mon[4:0];
                     if (nxt_mon == 8'h01) begin
                        tm_next[6] = nxt_yr;
                        if (nxt_yr == 8'h00) begin
                           tm_next[5][`RTC_CENT_MSB:`RTC_CENT_LSB] =
                              tm_reg[5][`RTC_CENT_MSB:`RTC_CENT_LSB] +
                              2'b01;
                        end
                     end
                  end
               end
            end
         end
      end
   end

   // Register store, a write reloads the byte
   generate
      for (genvar g = 0; g < 8; g++) begin : g_tm
         always_ff @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               tm_reg[g] <= RST_TIME[8*g +: 8];
            end else if (wr_stb && i_wr_addr == 3'(g)) begin
               tm_reg[g] <= i_wr_data;
            end else begin
               tm_reg[g] <= tm_next[g];
            end
         end
         assign tm_flat[8*g +: 8] = tm_reg[g];
      end
   endgenerate

   // Snapshot answer to the bus domain
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_snap_ack  <= 1'b0;
         o_snap_data <= `RTC_RST_TIME;
      end else if (req_sync_reg[1] != o_snap_ack) begin
         o_snap_ack  <= req_sync_reg[1];
         o_snap_data <= tm_flat;
      end
   end

endmodule
`default_nettype wire

// File: rtc_mst.sv
// Two-wire bus master model driving the clock's serial port
// Assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module rtc_mst #(
   parameter int HALF = 200
) (
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_oe
);
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   task automatic start();
      #(HALF/2) o_sda_oe = 1'b0;
      #(HALF/2) o_scl = 1'b1;
      #HALF o_sda_oe = 1'b1;
      #HALF o_scl = 1'b0;
   endtask
   task automatic stop();
      #(HALF/2) o_sda_oe = 1'b1;
      #(HALF/2) o_scl = 1'b1;
      #HALF o_sda_oe = 1'b0;
      #HALF;
   endtask
   task automatic bit_io(input logic b, output logic s);
      #(HALF/2) o_sda_oe = ~b;
      #(HALF/2) o_scl = 1'b1;
      #(HALF/2) s = i_sda;
      #(HALF/2) o_scl = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic s);
      logic t;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], t);
         q[i] = t;
      end
      bit_io(a, s);
   endtask
endmodule
`default_nettype wire

// File: rtc_pkg.sv
// Types shared by the clock design files
// Assumes nothing of its surroundings
package rtc_pkg;

   typedef logic [7:0] rtc_byte_t;

   typedef enum logic [3:0] {
      st_idle,
      st_addr,
      st_aack,
      st_ptr,
      st_pack,
      st_wdat,
      st_wack,
      st_rdat,
      st_rack,
      st_wait
   } rtc_state_e;

endpackage

// File: rtc_top.sv
// Two-wire slave front end with readable register copy
// Assumes bus pins are sampled on i_bus_clk, far faster than SCL
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"

module rtc_top
   import rtc_pkg::*;
#(
   parameter int OSC_HZ = `RTC_OSC_HZ
) (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   input  wire logic i_bus_clk,
   input  wire logic i_scl,
   input  wire logic i_sda_in,
   input  wire logic i_crystal_in,
   output logic      o_sda_out,
   output logic      o_sda_oe
);

   localparam logic [63:0] RST_TIME = `RTC_RST_TIME;

   logic        rst_meta_reg;
   logic        bus_nrst_reg;
   logic [2:0]  scl_sync_reg;
   logic [2:0]  sda_sync_reg;
   logic [2:0]  ack_sync_reg;
   logic        scl_s, scl_p, sda_s, sda_p;
   logic        scl_rise, scl_fall;
   logic        start_det, stop_det;
   rtc_state_e  state_reg, state_next;
   logic [3:0]  bit_reg;
   logic [7:0]  shift_reg;
   logic [2:0]  ptr_reg;
   logic        sda_oe_reg, sda_oe_next;
   logic        ptr_ld, ptr_inc, wr_go;
   logic        byte_end;
   logic        addr_hit;
   logic        rx_state;
   logic        reading;
   logic        freeze;
   rtc_byte_t   shadow_reg [8];
   logic [63:0] shadow_flat;
   rtc_byte_t   tx_byte;
   logic        tx_msb;
   logic        wr_tgl_reg;
   logic [2:0]  wr_addr_reg;
   logic [7:0]  wr_data_reg;
   logic        req_reg;
   logic [1:0]  skip_reg;
   logic        snap_arrive;
   logic        snap_take;
   logic        snap_ack;
   logic [63:0] snap_data;

   assign o_sda_out = 1'b0;
   assign o_sda_oe  = sda_oe_reg;

   // Bus-domain reset, asynchronous entry, clocked release
   always_ff @(posedge i_bus_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_meta_reg <= 1'b0;
         bus_nrst_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         bus_nrst_reg <= rst_meta_reg;
      end
   end

   // Pin synchronisers with one delay stage for edges
   always_ff @(posedge i_bus_clk or negedge bus_nrst_reg) begin
      if (!bus_nrst_reg) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
         ack_sync_reg <= 3'h0;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], i_scl};
         sda_sync_reg <= {sda_sync_reg[1:0], i_sda_in};
         ack_sync_reg <= {ack_sync_reg[1:0], snap_ack};
      end
   end

   assign scl_s    = scl_sync_reg[1];
   assign scl_p    = scl_sync_reg[2];
   assign sda_s    = sda_sync_reg[1];
   assign sda_p    = sda_sync_reg[2];
   assign scl_rise = scl_s & ~scl_p;
   assign scl_fall = ~scl_s & scl_p;
   // Clock high across the data edge, data high before a start, low before a stop
   assign start_det = scl_s & scl_p & sda_p & ~sda_s;
   assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;

   assign byte_end = scl_fall && (bit_reg == 4'd8);
   assign addr_hit = (shift_reg[7:1] == `RTC_SLAVE_ADDR);
   assign rx_state = (state_reg == st_addr) || (state_reg == st_ptr) ||
                     (state_reg == st_wdat);
   assign tx_byte  = shadow_reg[ptr_reg];
   assign tx_msb   = tx_byte[7];
   assign reading  = (state_reg == st_rdat) || (state_reg == st_rack);
   assign freeze   = reading && (ptr_reg <= `RTC_LAST_CLOCK_ADDR);

   // Protocol sequencing
   always_comb begin
      state_next  = state_reg;
      sda_oe_next = sda_oe_reg;
      ptr_ld      = 1'b0;
      ptr_inc     = 1'b0;
      wr_go       = 1'b0;
      if (stop_det) begin
         state_next  = st_idle;
         sda_oe_next = 1'b0;
      end else if (start_det) begin
         state_next  = st_addr;
         sda_oe_next = 1'b0;
      end else begin
         case (state_reg)
            st_idle, st_wait: begin
               state_next = state_reg;
            end
            st_addr: begin
               if (byte_end) begin
                  if (addr_hit) begin
                     state_next  = st_aack;
                     sda_oe_next = 1'b1;
                  end else begin
                     state_next = st_idle;
                  end
               end
            end
            st_aack: begin
               if (scl_fall) begin
                  // Direction bit picks read or pointer byte
                  state_next  = shift_reg[0] ? st_rdat : st_ptr;
                  sda_oe_next = shift_reg[0] & ~tx_msb;
               end
            end
            st_ptr: begin
               if (byte_end) begin
                  state_next  = st_pack;
                  sda_oe_next = 1'b1;
                  ptr_ld      = 1'b1;
               end
            end
            st_pack, st_wack: begin
               if (scl_fall) begin
                  state_next  = st_wdat;
                  sda_oe_next = 1'b0;
               end
            end
            st_wdat: begin
               if (byte_end) begin
                  state_next  = st_wack;
                  sda_oe_next = 1'b1;
                  wr_go       = 1'b1;
               end
            end
            st_rdat: begin
               if (scl_fall) begin
                  if (bit_reg == 4'd8) begin
                     state_next  = st_rack;
                     sda_oe_next = 1'b0;
                  end else begin
                     sda_oe_next = ~tx_byte[3'd7 - bit_reg[2:0]];
                  end
               end
            end
            st_rack: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     state_next = st_wait;
                  end else begin
                     state_next = st_rdat;
                     ptr_inc    = 1'b1;
                  end
               end
            end
            default: begin
               state_next = st_idle;
            end
         endcase
      end
   end

   always_ff @(posedge i_bus_clk or negedge bus_nrst_reg) begin
      if (!bus_nrst_reg) begin
         state_reg <= st_idle;
      end else begin
         state_reg <= state_next;
      end
   end

   // Open-drain data drive, changed on clock falls, released on start or stop
   always_ff @(posedge i_bus_clk or negedge bus_nrst_reg) begin
      if (!bus_nrst_reg) begin
         sda_oe_reg <= 1'b0;
      end else begin
         sda_oe_reg <= sda_oe_next;
      end
   end

   // Bit counter of the current byte
   always_ff @(posedge i_bus_clk or negedge bus_nrst_reg) begin
      if (!bus_nrst_reg) begin
         bit_reg <= 4'd0;
      end else if (start_det || stop_det || state_next != state_reg) begin
         bit_reg <= 4'd0;
      end else if (scl_rise && bit_reg != 4'd8) begin
         bit_reg <= bit_reg + 4'd1;
      end
   end

   // Receive shifter, MSB first
   always_ff @(posedge i_bus_clk or negedge bus_nrst_reg) begin
      if (!bus_nrst_reg) begin
         shift_reg <= 8'h00;
      end else if (scl_rise && rx_state) begin
         shift_reg <= {shift_reg[6:0], sda_s};
      end
   end

   // Word-address pointer, kept across transfers
   always_ff @(posedge i_bus_clk or negedge bus_nrst_reg) begin
      if (!bus_nrst_reg) begin
         ptr_reg <= `RTC_REG_SEC;
      end else if (ptr_ld) begin
         ptr_reg <= shift_reg[2:0];
      end else if (ptr_inc || wr_go) begin
         ptr_reg <= ptr_reg + 3'd1;
      end
   end

   // Write request toward the timekeeping domain
   always_ff @(posedge i_bus_clk or negedge bus_nrst_reg) begin
      if (!bus_nrst_reg) begin
         wr_tgl_reg  <= 1'b0;
         wr_addr_reg <= `RTC_REG_SEC;
         wr_data_reg <= 8'h00;
      end else if (wr_go) begin
         wr_tgl_reg  <= ~wr_tgl_reg;
         wr_addr_reg <= ptr_reg;
         wr_data_reg <= shift_reg;
      end
   end

   // Snapshot handshake, one request outstanding
   assign snap_arrive = ack_sync_reg[1] != ack_sync_reg[2];
   assign snap_take   = snap_arrive && !freeze && (skip_reg == 2'd0);

   always_ff @(posedge i_bus_clk or negedge bus_nrst_reg) begin
      if (!bus_nrst_reg) begin
         req_reg <= 1'b0;
      end else if (ack_sync_reg[1] == req_reg) begin
         req_reg <= ~req_reg;
      end
   end

   // Drop snapshots that may predate a write
   always_ff @(posedge i_bus_clk or negedge bus_nrst_reg) begin
      if (!bus_nrst_reg) begin
         skip_reg <= 2'd0;
      end else if (wr_go) begin
         skip_reg <= 2'd2;
      end else if (snap_arrive && skip_reg != 2'd0) begin
         skip_reg <= skip_reg - 2'd1;
      end
   end

   // Readable register copy
   generate
      for (genvar g = 0; g < 8; g++) begin : g_shadow
         always_ff @(posedge i_bus_clk or negedge bus_nrst_reg) begin
            if (!bus_nrst_reg) begin
               shadow_reg[g] <= RST_TIME[8*g +: 8];
            end else if (wr_go && ptr_reg == 3'(g)) begin
               shadow_reg[g] <= shift_reg;
            end else if (snap_take) begin
               shadow_reg[g] <= snap_data[8*g +: 8];
            end
         end
         assign shadow_flat[8*g +: 8] = shadow_reg[g];
      end
   endgenerate

   rtc_core #(
      .OSC_HZ (OSC_HZ)
   ) u_core (
      .i_clk        (i_clk),
      .i_nrst       (i_nrst),
      .i_crystal_in (i_crystal_in),
      .i_wr_tgl     (wr_tgl_reg),
      .i_wr_addr    (wr_addr_reg),
      .i_wr_data    (wr_data_reg),
      .i_snap_req   (req_reg),
      .o_snap_ack   (snap_ack),
      .o_snap_data  (snap_data)
   );

   // Checks on the bus side
   default clocking cb @(posedge i_bus_clk);
   endclocking
   default disable iff (!bus_nrst_reg);

   addr_miss_a: assert property (
      (state_reg == st_addr && byte_end && !addr_hit &&
       !start_det && !stop_det) |=> state_reg == st_idle && !sda_oe_reg)
      else $error("foreign address not ignored");

   idle_start_a: assert property (
      (state_reg == st_idle ##1 state_reg == st_addr) |->
      $past(scl_sync_reg[2], 2) && $past(sda_sync_reg[2], 2))
      else $error("transfer began from a busy bus");

   start_addr_a: assert property (
      start_det |=> state_reg == st_addr && bit_reg == 4'd0)
      else $error("start not taken");

   stop_idle_a: assert property (
      stop_det |=> state_reg == st_idle && !sda_oe_reg)
      else $error("stop did not end transfer");

   drive_low_clk_a: assert property (
      ($changed(sda_oe_reg) && state_reg != st_idle &&
       state_reg != st_addr) |-> !$past(scl_sync_reg[1]))
      else $error("data drive changed with clock high");

   first_bit_a: assert property (
      (state_reg == st_rdat && scl_fall && bit_reg == 4'd0 &&
       !start_det && !stop_det) |=> sda_oe_reg == !$past(tx_msb))
      else $error("first read bit is not the MSB");

   ack_hold_a: assert property (
      (state_reg == st_aack || state_reg == st_pack ||
       state_reg == st_wack) |-> sda_oe_reg)
      else $error("acknowledge not held low");

   nack_release_a: assert property (
      (state_reg == st_rack && scl_rise && sda_sync_reg[1] &&
       !start_det && !stop_det) |=> state_reg == st_wait && !sda_oe_reg)
      else $error("data not released after nack");

   ptr_load_a: assert property (
      (state_reg == st_ptr && byte_end && !start_det && !stop_det) |=>
      ptr_reg == $past(shift_reg[2:0]))
      else $error("pointer not loaded");

   wr_adv_a: assert property (
      (state_reg == st_wdat && byte_end && !start_det && !stop_det) |=>
      ptr_reg == $past(ptr_reg) + 3'd1 && wr_tgl_reg != $past(wr_tgl_reg))
      else $error("write not issued or pointer stuck");

   rd_adv_a: assert property (
      (state_reg == st_rack && scl_rise && !sda_sync_reg[1] &&
       !start_det && !stop_det) |=> ptr_reg == $past(ptr_reg) + 3'd1)
      else $error("pointer not advanced on read ack");

   freeze_hold_a: assert property (
      (freeze && !wr_go) |=> $stable(shadow_flat))
      else $error("readable copy changed during clock read");

   write_seen_c: cover property (state_reg == st_wack);
   read_ack_c:   cover property (state_reg == st_rack ##1
                                 state_reg == st_rdat);
   read_nack_c:  cover property (state_reg == st_rack ##1
                                 state_reg == st_wait);
   frozen_c:     cover property (freeze && snap_arrive);

endmodule
`default_nettype wire

// File: tb_rtc_two_wire_register_access.sv
// Bench for the clock's serial port and timekeeping
// Assumes rtc_mst as bus master and a pull-up on the data wire
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"
module tb_rtc_two_wire_register_access;
   import rtc_pkg::*;
   logic        clk = 1'b0;
   logic        bclk = 1'b0;
   logic        nrst = 1'b0;
   logic        crys = 1'b0;
   logic [63:0] rst_t = `RTC_RST_TIME;
   wire logic   scl;
   wire logic   m_oe;
   wire logic   d_oe;
   wire logic   sda;
   int          bad_count = 0;
   int          checked = 0;
   assign sda = ~(m_oe | d_oe);
   always #2.5 clk = ~clk;
   always #6 bclk = ~bclk;
   rtc_top #(.OSC_HZ(4)) u_rtc_top (.i_clk(clk), .i_nrst(nrst),
      .i_bus_clk(bclk), .i_scl(scl), .i_sda_in(sda),
      .i_crystal_in(crys), .o_sda_out(), .o_sda_oe(d_oe));
   rtc_mst u_rtc_mst (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
   task automatic wrap_up();
      if (bad_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      checked++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask
   task automatic wb(input rtc_byte_t d, input logic a);
      rtc_byte_t q;
      logic      s;
      u_rtc_mst.xfer(d, 1'b1, q, s);
      chk("ack", {7'h00, ~a}, {7'h00, s});
   endtask
   task automatic rb(input rtc_byte_t e, input logic last);
      rtc_byte_t q;
      logic      s;
      u_rtc_mst.xfer(8'hFF, last, q, s);
      chk("rdat", e, q);
      #100;
      if (last) chk("release", 8'h01, {7'h00, sda});
   endtask
   task automatic wr_at(input rtc_byte_t p, input rtc_byte_t d);
      u_rtc_mst.start();
      wb(8'hD0, 1'b1);
      wb(p, 1'b1);
      wb(d, 1'b1);
      u_rtc_mst.stop();
      #500;
   endtask
   task automatic rd_at(input rtc_byte_t p, input rtc_byte_t e);
      u_rtc_mst.start();
      wb(8'hD0, 1'b1);
      wb(p, 1'b1);
      u_rtc_mst.start();
      wb(8'hD1, 1'b1);
      rb(e, 1'b1);
      u_rtc_mst.stop();
   endtask
   task automatic xtal(input int n);
      repeat (2 * n) begin
         repeat (4) @(posedge clk);
         #1 crys = ~crys;
      end
      #500;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1 nrst = 1'b1;
      #500;
      u_rtc_mst.start();
      wb(8'hD1, 1'b1);
      for (int i = 0; i < 8; i++) rb(rst_t[8*i +: 8], i == 7);
      u_rtc_mst.stop();
      u_rtc_mst.start();
      wb(8'hA0, 1'b0);
      u_rtc_mst.stop();
      u_rtc_mst.start();
      wb(8'hD0, 1'b1);
      wb(8'h07, 1'b1);
      wb(8'h5A, 1'b1);
      wb(8'hA5, 1'b1);
      u_rtc_mst.stop();
      u_rtc_mst.start();
      wb(8'hD1, 1'b1);
      rb(8'h00, 1'b1);
      u_rtc_mst.stop();
      u_rtc_mst.start();
      wb(8'hD0, 1'b1);
      wb(8'h07, 1'b1);
      u_rtc_mst.start();
      wb(8'hD1, 1'b1);
      rb(8'h5A, 1'b0);
      rb(8'hA5, 1'b1);
      u_rtc_mst.stop();
      u_rtc_mst.start();
      wb(8'hD1, 1'b1);
      rb(8'hA5, 1'b1);
      u_rtc_mst.stop();
      xtal(8);
      rd_at(8'h00, 8'hA5);
      wr_at(8'h00, 8'h00);
      xtal(8);
      rd_at(8'h00, 8'h02);
      wr_at(8'h00, 8'h10);
      xtal(3);
      wr_at(8'h00, 8'h10);
      xtal(3);
      rd_at(8'h00, 8'h10);
      wrap_up();
   end
   initial begin
      #400000;
      bad_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
